// [inc/uart_line_defines.svh]
// offsets, field positions, reset values and counts of the quad serial line
`ifndef UART_LINE_DEFINES_SVH
`define UART_LINE_DEFINES_SVH
// register word indexes inside one channel window (byte address = 4 * index)
`define IDX_DATA    4'h0
`define IDX_IER     4'h1
`define IDX_ISR     4'h2
`define IDX_LCR     4'h3
`define IDX_MCR     4'h4
`define IDX_LSR     4'h5
`define IDX_MSR     4'h6
`define IDX_SPR     4'h7
`define IDX_DIV     4'h8
// address fields: channel_select_addr and register index
`define ADDR_CH_HI  7
`define ADDR_CH_LO  6
`define ADDR_IX_HI  5
`define ADDR_IX_LO  2
// modem_control_reg bits
`define MCR_DTR     0
`define MCR_RTS     1
`define MCR_INTEN   3
`define MCR_LOOP    4
// interrupt enable bits
`define IER_RX      0
`define IER_THRE    1
`define IER_LS      2
`define IER_MS      3
// reset values
`define IER_RST     8'h00
`define LCR_RST     8'h03
`define MCR_RST     8'h00
`define DIV_RST     16'h0001
// interrupt status codes, highest priority first
`define ISR_LS      4'h6
`define ISR_RX      4'h4
`define ISR_THRE    4'h2
`define ISR_MS      4'h0
`define ISR_NONE    4'h1
// oversampling: sixteen ticks per bit, start checked at mid bit
`define TICK_LAST   4'hF
`define TICK_MID    4'h7
`endif

// [inc/uart_line_pkg.sv]
// types shared by the quad serial line block
`default_nettype none
package uart_line_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} tx_state_e;
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} rx_state_e;
endpackage
`default_nettype wire

// [inc/chan_if.sv]
// signals between the register side and one serial channel core
`default_nettype none
interface chan_if;
	import uart_line_pkg::*;
	logic [15:0] div;
	logic [1:0]  word_len;
	logic        two_stop;
	logic        par_en;
	logic        par_even;
	byte_t       tx_data;
	logic        tx_load;
	logic        tx_hold_empty;
	logic        tx_empty;
	logic        tx_serial;
	logic        rx_serial;
	byte_t       rx_data;
	logic        rx_done;
	logic        rx_par_err;
	logic        rx_frm_err;
	modport core (input div, word_len, two_stop, par_en, par_even, tx_data,
		tx_load, rx_serial, output tx_hold_empty, tx_empty, tx_serial,
		rx_data, rx_done, rx_par_err, rx_frm_err);
	modport regs (output div, word_len, two_stop, par_en, par_even, tx_data,
		tx_load, rx_serial, input tx_hold_empty, tx_empty, tx_serial,
		rx_data, rx_done, rx_par_err, rx_frm_err);
endinterface
`default_nettype wire

// [rtl/uart_channel_core.sv]
// one serial channel: baud divider, framing transmitter and receiver
`include "uart_line_defines.svh"
`default_nettype none
module uart_channel_core
(
	input  wire logic sys_clk_in,
	input  wire logic sys_rst_in,
	chan_if.core      ch
);
	import uart_line_pkg::*;

	// parity of the active data bits, even or odd
	function automatic logic par_of(input byte_t d, input logic [1:0] wl,
		input logic even);
		byte_t m;
		m = d & (8'hFF >> (2'd3 - wl));
		return even ? ^m : ~^m;
	endfunction

	logic [15:0] bcnt_r;
	logic        tick;
	tx_state_e   tst_r;
	rx_state_e   rxs_r;
	byte_t       hold_r;
	byte_t       tsh_r;
	byte_t       rsh_r;
	byte_t       rdat_r;
	logic        hold_full_r;
	logic        txd_r;
	logic        tpar_r;
	logic        tstop2_r;
	logic        rpar_r;
	logic        done_r;
	logic        perr_r;
	logic        ferr_r;
	logic [3:0]  tsub_r;
	logic [3:0]  rsub_r;
	logic [2:0]  tbit_r;
	logic [2:0]  rbit_r;
	logic [2:0]  last_bit;
	logic        tend;
	logic        rend;
	logic        rmid;
	byte_t       rx_al;

	// ----------------------------------------
	// sixteen-times bit rate enable
	// ----------------------------------------
	assign tick     = (bcnt_r <= 16'h0001);
	assign last_bit = {1'b0, ch.word_len} + 3'd4;
	assign tend     = tick && (tsub_r == `TICK_LAST);
	assign rend     = tick && (rsub_r == `TICK_LAST);
	assign rmid     = tick && (rsub_r == `TICK_MID);
	assign rx_al    = rsh_r >> (2'd3 - ch.word_len);

	// reload the divider each tick
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
			bcnt_r <= `DIV_RST;
		else
			bcnt_r <= tick ? ch.div : bcnt_r - 16'h0001;

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	assign ch.tx_hold_empty = !hold_full_r;
	assign ch.tx_empty      = !hold_full_r && (tst_r == TX_IDLE);
	assign ch.tx_serial     = txd_r;

	// holding register: a new load wins over the move to the shifter
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
		begin
			hold_r      <= 8'h00;
			hold_full_r <= 1'b0;
		end
		else if (ch.tx_load)
		begin
			hold_r      <= ch.tx_data;
			hold_full_r <= 1'b1;
		end
		else if (tst_r == TX_IDLE)
			hold_full_r <= 1'b0;

	// tick count inside the current bit
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
			tsub_r <= 4'h0;
		else if (tst_r == TX_IDLE)
			tsub_r <= 4'h0;
		else if (tick)
			tsub_r <= tsub_r + 4'h1;

	// frame: start, data lsb first, parity, stop; line idles high
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
		begin
			tst_r    <= TX_IDLE;
			txd_r    <= 1'b1;                            // [R09]
			tsh_r    <= 8'h00;
			tbit_r   <= 3'h0;
			tpar_r   <= 1'b0;
			tstop2_r <= 1'b0;
		end
		else
			case (tst_r)
				TX_IDLE:
					if (hold_full_r)
					begin
						tsh_r  <= hold_r;
						tpar_r <= par_of(hold_r, ch.word_len, ch.par_even); // [R12]
						txd_r  <= 1'b0;                    // [R11]
						tst_r  <= TX_START;
					end
				TX_START:
					if (tend)
					begin
						txd_r  <= tsh_r[0];
						tbit_r <= 3'h0;
						tst_r  <= TX_DATA;
					end
				TX_DATA:
					if (tend)
					begin
						tsh_r <= {1'b0, tsh_r[7:1]};
						if (tbit_r == last_bit)
						begin
							txd_r    <= ch.par_en ? tpar_r : 1'b1; // [R12]
							tst_r    <= ch.par_en ? TX_PAR : TX_STOP;
							tstop2_r <= ch.two_stop;
						end
						else
						begin
							txd_r  <= tsh_r[1];
							tbit_r <= tbit_r + 3'h1;
						end
					end
				TX_PAR:
					if (tend)
					begin
						txd_r <= 1'b1;                     // [R11]
						tst_r <= TX_STOP;
					end
				TX_STOP:
					if (tend)
					begin
						if (tstop2_r)
							tstop2_r <= 1'b0;
						else
							tst_r <= TX_IDLE;
					end
				default:
					tst_r <= TX_IDLE;
			endcase

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	assign ch.rx_data    = rdat_r;
	assign ch.rx_done    = done_r;
	assign ch.rx_par_err = perr_r;
	assign ch.rx_frm_err = ferr_r;

	// tick count, realigned to mid bit once the start is confirmed
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
			rsub_r <= 4'h0;
		else if (rxs_r == RX_IDLE || (rxs_r == RX_START && rmid))
			rsub_r <= 4'h0;
		else if (tick)
			rsub_r <= rsub_r + 4'h1;

	// sample each bit at its middle, check parity and stop
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
		begin
			rxs_r  <= RX_IDLE;
			rsh_r  <= 8'h00;
			rbit_r <= 3'h0;
			rpar_r <= 1'b0;
			rdat_r <= 8'h00;
			done_r <= 1'b0;
			perr_r <= 1'b0;
			ferr_r <= 1'b0;
		end
		else
		begin
			done_r <= 1'b0;
			case (rxs_r)
				RX_IDLE:
					if (!ch.rx_serial && tick)
						rxs_r <= RX_START;
				RX_START:
					if (rmid)
					begin
						rbit_r <= 3'h0;
						rpar_r <= 1'b0;
						rxs_r  <= ch.rx_serial ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (rend)
					begin
						rsh_r <= {ch.rx_serial, rsh_r[7:1]};
						if (rbit_r == last_bit)
							rxs_r <= ch.par_en ? RX_PAR : RX_STOP;
						else
							rbit_r <= rbit_r + 3'h1;
					end
				RX_PAR:
					if (rend)
					begin
						rpar_r <= ch.rx_serial;
						rxs_r  <= RX_STOP;
					end
				RX_STOP:
					if (rend)
					begin
						rdat_r <= rx_al;
						ferr_r <= !ch.rx_serial;
						perr_r <= ch.par_en && (rpar_r !=
							par_of(rx_al, ch.word_len, ch.par_even)); // [R12]
						done_r <= 1'b1;
						rxs_r  <= RX_IDLE;
					end
				default:
					rxs_r <= RX_IDLE;
			endcase
		end
endmodule
`default_nettype wire

// [rtl/quad_uart_line.sv]
// four serial channels with modem lines behind an apb register slave
// Notes on behaviour
// R01 - modem pulls carrier_detect_n low on a carrier.
// R02 - clear-to-send level readable in modem_status_reg bit 4.
// R03 - data-set-ready reported only; no effect on data flow.
// R04 - control bit 0 set drives terminal-ready low, clear drives high.
// R05 - ring_indicator_n rising to 1 raises a modem status interrupt.
// R06 - control bit 1 set drives request-to-send low; no data effect.
// R07 - request-to-send output is 1 after reset on every channel.
// R08 - far end idles its transmit line high.
// R09 - transmit output high in reset, idle and while transmitter off.
// R10 - loop-back ignores receive pin and feeds transmit data inward.
// R11 - transmitter serialises each character inside start and stop bits.
// R12 - optional parity bit added on transmit and checked on receive.
// R13 - style input plus control bit 3 choose gated or continuous irq.
// R14 - two host styles: chip-select and address-select.
// R15 - style input low decodes channel_select_addr to pick a channel.
// R16 - modem status shows each active-low input inverted.
// R17 - ring interrupt needs modem status interrupts enabled.
`include "uart_line_defines.svh"
`default_nettype none
module quad_uart_line
#(
	parameter int NCH = 4
)
(
	input  wire logic        sys_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        bus_style_in,
	input  wire logic [3:0]  chan_cs_n_in,
	input  wire logic        interrupt_style_select_in,
	input  wire logic [3:0]  rx_in,
	input  wire logic [3:0]  cts_n_in,
	input  wire logic [3:0]  dsr_n_in,
	input  wire logic [3:0]  carrier_detect_n_in,
	input  wire logic [3:0]  ring_indicator_n_in,
	output logic      [3:0]  tx_out,
	output logic      [3:0]  dtr_n_out,
	output logic      [3:0]  rts_n_out,
	output logic      [3:0]  irq_out,
	output logic             irq_n_out,
	output logic             irq_n_oe_out
);
	import uart_line_pkg::*;

	// first channel whose select is low
	function automatic logic [1:0] cs_chan(input logic [3:0] cs_n);
		logic [1:0] c;
		c = 2'h3;
		if (!cs_n[0])
			c = 2'h0;
		else if (!cs_n[1])
			c = 2'h1;
		else if (!cs_n[2])
			c = 2'h2;
		return c;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [25:0] pin_raw;
	logic [25:0] pin_s1_r;
	logic [25:0] pin_s2_r;
	logic [3:0]  rx_s;
	logic [3:0]  cts_s;
	logic [3:0]  dsr_s;
	logic [3:0]  cd_s;
	logic [3:0]  ri_s;
	logic [3:0]  cs_n_s;
	logic        style_s;
	logic        isel_s;

	assign pin_raw = {interrupt_style_select_in, bus_style_in, chan_cs_n_in,
		ring_indicator_n_in, carrier_detect_n_in, dsr_n_in, cts_n_in, rx_in};
	assign {isel_s, style_s, cs_n_s, ri_s, cd_s, dsr_s, cts_s, rx_s} = pin_s2_r;

	// two flops per pin; idle lines reset high
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
		begin
			pin_s1_r <= 26'h3FFFFFF;
			pin_s2_r <= 26'h3FFFFFF;
		end
		else
		begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic [1:0]  ch_sel;
	logic [3:0]  idx;
	logic        ch_ok;
	logic        idx_ok;
	logic        hit;
	logic        setup;
	logic        access;
	logic        wr_go;
	logic        rd_go;
	logic [31:0] prdata_r;
	logic [31:0] rd_val [NCH];
	logic [3:0]  pend_w;
	logic [3:0]  inten_w;
	logic [3:0]  irq_r;
	logic        irq_oe_r;

	// channel from select pins or from channel_select_addr
	assign ch_sel = style_s ? cs_chan(cs_n_s)                       // [R14]
		: paddr_in[`ADDR_CH_HI:`ADDR_CH_LO];                        // [R15]
	assign ch_ok  = !style_s || (cs_n_s != 4'hF);                   // [R14]
	assign idx    = paddr_in[`ADDR_IX_HI:`ADDR_IX_LO];
	assign idx_ok = (idx <= `IDX_DIV);
	assign hit    = ch_ok && idx_ok;
	assign setup  = psel_in && !penable_in;
	assign access = psel_in && penable_in;
	assign wr_go  = access && pwrite_in && hit;
	assign rd_go  = access && !pwrite_in && hit;

	// zero-wait slave; unmapped access gets an error
	assign pready_out  = 1'b1;
	assign pslverr_out = access && !hit;
	assign prdata_out  = prdata_r;

	// read data captured in the setup cycle
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
			prdata_r <= 32'h0000_0000;
		else if (setup)
			prdata_r <= hit ? rd_val[ch_sel] : 32'h0000_0000;

	// ----------------------------------------
	// per channel registers and modem lines
	// ----------------------------------------
	for (genvar g = 0; g < NCH; g++)
	begin : g_ch
		chan_if cif();
		logic        wr;
		logic        rd;
		logic [7:0]  ier_r;
		logic [7:0]  lcr_r;
		logic [7:0]  mcr_r;
		logic [7:0]  spr_r;
		logic [7:0]  rhr_r;
		logic [15:0] div_r;
		logic        dr_r;
		logic        oe_r;
		logic        pe_r;
		logic        fe_r;
		logic [3:0]  lvl;
		logic [3:0]  lvl_prev_r;
		logic [3:0]  dmsr_r;
		logic [3:0]  ev;
		logic [7:0]  modem_status_reg;
		logic [7:0]  lsr;
		logic [3:0]  isr;
		logic        loop;

		assign wr   = wr_go && (ch_sel == 2'(g));
		assign rd   = rd_go && (ch_sel == 2'(g));
		assign loop = mcr_r[`MCR_LOOP];

		// core configuration and loop-back routing
		assign cif.div       = div_r;
		assign cif.word_len  = lcr_r[1:0];
		assign cif.two_stop  = lcr_r[2];
		assign cif.par_en    = lcr_r[3];                          // [R12]
		assign cif.par_even  = lcr_r[4];
		assign cif.tx_data   = pwdata_in[7:0];
		assign cif.tx_load   = wr && (idx == `IDX_DATA);
		assign cif.rx_serial = loop ? cif.tx_serial : rx_s[g];    // [R10]
		assign tx_out[g]     = loop | cif.tx_serial;              // [R09]

		// modem outputs from control bits only, never from data flow
		assign dtr_n_out[g] = !mcr_r[`MCR_DTR];                   // [R04]
		assign rts_n_out[g] = !mcr_r[`MCR_RTS];                   // [R06] [R07]

		// asserted levels: cd, ri, dsr, cts; dsr feeds status only
		assign lvl = {!cd_s[g], !ri_s[g], !dsr_s[g], !cts_s[g]};  // [R16] [R03]
		// change events; ring counts only when the pin rises to 1
		assign ev  = {lvl[3] ^ lvl_prev_r[3], lvl_prev_r[2] & !lvl[2],
			lvl[1] ^ lvl_prev_r[1], lvl[0] ^ lvl_prev_r[0]};      // [R05]
		assign modem_status_reg = {lvl, dmsr_r};                               // [R02] [R01]
		assign lsr = {1'b0, cif.tx_empty, cif.tx_hold_empty, 1'b0,
			fe_r, pe_r, oe_r, dr_r};

		// interrupt source by priority
		assign isr = (ier_r[`IER_LS] && (oe_r || pe_r || fe_r)) ? `ISR_LS
			: (ier_r[`IER_RX] && dr_r) ? `ISR_RX
			: (ier_r[`IER_THRE] && cif.tx_hold_empty) ? `ISR_THRE
			: (ier_r[`IER_MS] && (dmsr_r != 4'h0)) ? `ISR_MS      // [R17]
			: `ISR_NONE;
		assign pend_w[g]  = (isr != `ISR_NONE);
		assign inten_w[g] = mcr_r[`MCR_INTEN];

		// register read view
		assign rd_val[g] = (idx == `IDX_DATA) ? {24'h0, rhr_r}
			: (idx == `IDX_IER) ? {24'h0, ier_r}
			: (idx == `IDX_ISR) ? {28'h0, isr}
			: (idx == `IDX_LCR) ? {24'h0, lcr_r}
			: (idx == `IDX_MCR) ? {24'h0, mcr_r}
			: (idx == `IDX_LSR) ? {24'h0, lsr}
			: (idx == `IDX_MSR) ? {24'h0, modem_status_reg}
			: (idx == `IDX_SPR) ? {24'h0, spr_r}
			: {16'h0, div_r};

		// software written configuration
		always_ff @(posedge sys_clk_in or posedge sys_rst_in)
			if (sys_rst_in)
			begin
				ier_r <= `IER_RST;
				lcr_r <= `LCR_RST;
				mcr_r <= `MCR_RST;                                // [R07]
				spr_r <= 8'h00;
				div_r <= `DIV_RST;
			end
			else if (wr)
			begin
				if (idx == `IDX_IER)
					ier_r <= {4'h0, pwdata_in[3:0]};
				else if (idx == `IDX_LCR)
					lcr_r <= pwdata_in[7:0];
				else if (idx == `IDX_MCR)
					mcr_r <= {3'h0, pwdata_in[4:0]};              // [R04] [R06]
				else if (idx == `IDX_SPR)
					spr_r <= pwdata_in[7:0];
				else if (idx == `IDX_DIV)
					div_r <= pwdata_in[15:0];
			end

		// line status: new events win over read clears
		always_ff @(posedge sys_clk_in or posedge sys_rst_in)
			if (sys_rst_in)
			begin
				rhr_r <= 8'h00;
				dr_r  <= 1'b0;
				oe_r  <= 1'b0;
				pe_r  <= 1'b0;
				fe_r  <= 1'b0;
			end
			else
			begin
				if (cif.rx_done)
					rhr_r <= cif.rx_data;
				dr_r <= cif.rx_done || (dr_r && !(rd && idx == `IDX_DATA));
				oe_r <= (cif.rx_done && dr_r && !(rd && idx == `IDX_DATA))
					|| (oe_r && !(rd && idx == `IDX_LSR && prdata_r[1]));
				pe_r <= (cif.rx_done && cif.rx_par_err)           // [R12]
					|| (pe_r && !(rd && idx == `IDX_LSR && prdata_r[2]));
				fe_r <= (cif.rx_done && cif.rx_frm_err)
					|| (fe_r && !(rd && idx == `IDX_LSR && prdata_r[3]));
			end

		// modem status deltas, cleared only where the read saw them
		always_ff @(posedge sys_clk_in or posedge sys_rst_in)
			if (sys_rst_in)
			begin
				lvl_prev_r <= 4'h0;
				dmsr_r     <= 4'h0;
			end
			else
			begin
				lvl_prev_r <= lvl;
				dmsr_r     <= ev | (dmsr_r &                      // [R05]
					~((rd && idx == `IDX_MSR) ? prdata_r[3:0] : 4'h0));
			end

		uart_channel_core u_core
		(
			.sys_clk_in (sys_clk_in),
			.sys_rst_in (sys_rst_in),
			.ch         (cif.core)
		);
	end

	// ----------------------------------------
	// interrupt outputs
	// ----------------------------------------
	assign irq_out      = irq_r;
	assign irq_n_out    = 1'b0;
	assign irq_n_oe_out = irq_oe_r;

	// per-channel lines in select style, shared open drain otherwise
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
		begin
			irq_r    <= 4'h0;
			irq_oe_r <= 1'b0;
		end
		else
		begin
			irq_r    <= style_s ? (pend_w & (isel_s ? 4'hF : inten_w)) // [R13]
				: 4'h0;
			irq_oe_r <= !style_s && (pend_w != 4'h0);             // [R14]
		end
endmodule
`default_nettype wire

// [tb/modem_model.sv]
// modem stand-in driving receive data and handshake lines per channel
`default_nettype none
module modem_model
(
	input  wire logic       sys_clk_in,
	output logic      [3:0] rx_out,
	output logic      [3:0] cts_n_out,
	output logic      [3:0] dsr_n_out,
	output logic      [3:0] carrier_detect_n_out,
	output logic      [3:0] ring_indicator_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// -----------------------------------------------
	// line idle and handshakes released from time zero
	// -----------------------------------------------
	initial
	begin
		rx_out = 4'hF;
		cts_n_out = 4'hF;
		dsr_n_out = 4'hF;
		carrier_detect_n_out = 4'hF;
		ring_indicator_n_out = 4'hF;
	end
	// assert handshakes of one channel, v is {cd, ri, dsr, cts}
	task lines(input int ch, input logic [3:0] v);
		@(posedge sys_clk_in);
		carrier_detect_n_out[ch] <= ~v[3];
		ring_indicator_n_out[ch] <= ~v[2];
		dsr_n_out[ch] <= ~v[1];
		cts_n_out[ch] <= ~v[0];
	endtask
	// one frame of 16-cycle bits: start, data lsb first, even parity
	task send(input int ch, input logic [7:0] b, input logic bad);
		int i;
		for (i = 0; i < 10; i++)
		begin
			@(posedge sys_clk_in);
			rx_out[ch] <= i == 0 ? 1'b0 : i == 9 ? ^b ^ bad : b[i - 1];
			repeat (15) @(posedge sys_clk_in);
		end
		@(posedge sys_clk_in);
		rx_out[ch] <= 1'b1; // stop, then idle
		repeat (16) @(posedge sys_clk_in);
	endtask
	// hold the line at a level; low is a commanded break
	task hold(input int ch, input logic v);
		@(posedge sys_clk_in);
		rx_out[ch] <= v;
	endtask
endmodule
`default_nettype wire

// [tb/quad_uart_line_sva.sv]
// concurrent checks on the quad serial line ports
`default_nettype none
module quad_uart_line_sva
(
	input wire logic        sys_clk_in,
	input wire logic        sys_rst_in,
	input wire logic [7:0]  paddr_in,
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pslverr_out,
	input wire logic        bus_style_in,
	input wire logic [3:0]  tx_out,
	input wire logic [3:0]  dtr_n_out,
	input wire logic [3:0]  rts_n_out,
	input wire logic [3:0]  irq_out,
	input wire logic        irq_n_out,
	input wire logic        irq_n_oe_out
);
	logic [3:0] sty_r;
	logic       acc;
	logic       wr_mcr;
	logic       sty_lo;
	logic       sty_hi;
	// -----------------------------------------------
	// style history covers the input sync and irq flop
	// -----------------------------------------------
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
			sty_r <= 4'hF;
		else
			sty_r <= {sty_r[2:0], bus_style_in};
	assign acc = psel_in && penable_in;
	assign wr_mcr = acc && pwrite_in && paddr_in[5:2] == 4'h4;
	assign sty_lo = sty_r == 4'h0 && !bus_style_in;
	assign sty_hi = sty_r == 4'hF && bus_style_in;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_mcr_addr;
		wr_mcr && sty_lo;
	endsequence
	AST_RST_LVL:
	assert property ($fell(sys_rst_in) |-> tx_out == 4'hF &&
		rts_n_out == 4'hF && dtr_n_out == 4'hF)
		else $error("pins not idle after reset");
	AST_DTR:
	assert property (s_mcr_addr |=>
		dtr_n_out[$past(paddr_in[7:6])] == !$past(pwdata_in[0]))
		else $error("terminal ready not set by control write");
	AST_RTS:
	assert property (s_mcr_addr |=>
		rts_n_out[$past(paddr_in[7:6])] == !$past(pwdata_in[1]))
		else $error("request to send not set by control write");
	AST_PIN_HOLD:
	assert property (!$stable({dtr_n_out, rts_n_out}) |-> $past(wr_mcr))
		else $error("control pins moved without a write");
	AST_ERR_PHASE:
	assert property (pslverr_out |-> acc)
		else $error("error outside access phase");
	AST_ERR_IDX:
	assert property (acc && sty_lo && paddr_in[5:2] > 4'h8 |-> pslverr_out)
		else $error("unmapped index accepted");
	AST_ERR_DATA:
	assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
		else $error("refused read returned data");
	AST_IRQ_STYLE:
	assert property (sty_lo |-> irq_out == 4'h0)
		else $error("channel irq active in address style");
	AST_OE_STYLE:
	assert property (sty_hi |-> !irq_n_oe_out && irq_n_out == 1'b0)
		else $error("shared irq driven in select style");
endmodule
bind quad_uart_line quad_uart_line_sva quad_uart_line_sva_inst (
	.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
	.paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
	.prdata_out(prdata_out), .pslverr_out(pslverr_out),
	.bus_style_in(bus_style_in), .tx_out(tx_out),
	.dtr_n_out(dtr_n_out), .rts_n_out(rts_n_out), .irq_out(irq_out),
	.irq_n_out(irq_n_out), .irq_n_oe_out(irq_n_oe_out));
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the quad serial line block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;
	} row_s;
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic bus_style, isel, irq_n, irq_oe, rerr;
	logic [3:0] cs_n, rx, cts_n, dsr_n, cd_n, ri_n, tx, dtr_n, rts_n, irq;
	int checks, bad_count;
	row_s rows [11] = '{'{8'h0C, 0, 0, 3, 0}, '{8'h20, 0, 0, 1, 0},
		'{8'h44, 0, 0, 0, 0}, '{8'hD0, 0, 0, 0, 0}, '{8'h5C, 1, 8'h5A, 0, 0},
		'{8'h5C, 0, 0, 8'h5A, 0}, '{8'h1C, 0, 0, 0, 0}, '{8'h24, 0, 0, 0, 1},
		'{8'h90, 1, 3, 0, 0}, '{8'h90, 0, 0, 3, 0}, '{8'hD8, 0, 0, 0, 0}};
	quad_uart_line quad_uart_line_inst (
		.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .paddr_in(paddr),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .bus_style_in(bus_style),
		.chan_cs_n_in(cs_n), .interrupt_style_select_in(isel), .rx_in(rx),
		.cts_n_in(cts_n), .dsr_n_in(dsr_n), .carrier_detect_n_in(cd_n),
		.ring_indicator_n_in(ri_n), .tx_out(tx), .dtr_n_out(dtr_n),
		.rts_n_out(rts_n), .irq_out(irq), .irq_n_out(irq_n),
		.irq_n_oe_out(irq_oe));
	modem_model modem_model_inst (.sys_clk_in(sys_clk), .rx_out(rx),
		.cts_n_out(cts_n), .dsr_n_out(dsr_n),
		.carrier_detect_n_out(cd_n), .ring_indicator_n_out(ri_n));
	// -----------------------------------------------
	// clock, watchdog and shared tasks
	// -----------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		results();
	end
	task results;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, x, s);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		{paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		chk("prdata", rdat, x);
	endtask
	// watch one frame on channel 0 at mid bit
	task txf(input logic [7:0] d, input logic p);
		int i;
		while (tx[0] !== 1'b0)
			@(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
		chk("tx start", 32'(tx[0]), 0);
		for (i = 0; i < 8 + p; i++)
		begin
			repeat (16) @(posedge sys_clk);
			chk("tx bit", 32'(tx[0]), i < 8 ? d[i] : ^d);
		end
		repeat (16) @(posedge sys_clk);
		chk("tx stop", 32'(tx[0]), 1);
		repeat (16) @(posedge sys_clk);
		chk("tx idle", 32'(tx[0]), 1);
	endtask
	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial
	begin
		int i;
		logic lo;
		{sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
		{bus_style, isel, cs_n} = 6'h0F;
		repeat (8) @(posedge sys_clk);
		chk("tx reset", 32'(tx), 4'hF);
		chk("rts reset", 32'(rts_n), 4'hF);
		sys_rst <= 1'b0;
		@(posedge sys_clk); // style sync settles first
		for (i = 0; i < 11; i++)
		begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w)
				chk("row data", rdat, rows[i].x);
			chk("row error", 32'(rerr), 32'(rows[i].e));
		end
		chk("dtr", 32'(dtr_n), 4'hB);
		chk("rts", 32'(rts_n), 4'hB);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("rts mid reset", 32'(rts_n), 4'hF);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(8'h90, 0);
		$display("test registers done");
		modem_model_inst.lines(0, 4'h1);
		repeat (4) @(posedge sys_clk);
		rd(8'h18, 8'h11);
		modem_model_inst.lines(0, 4'hF);
		repeat (4) @(posedge sys_clk);
		rd(8'h18, 8'hFA);
		rd(8'h18, 8'hF0);
		modem_model_inst.lines(0, 4'h0);
		repeat (4) @(posedge sys_clk);
		chk("oe masked", 32'(irq_oe), 0);
		wr(8'h04, 8'h08);
		repeat (3) @(posedge sys_clk);
		chk("oe ring", 32'(irq_oe), 1);
		rd(8'h18, 8'h0F);
		repeat (3) @(posedge sys_clk);
		chk("oe cleared", 32'(irq_oe), 0);
		wr(8'h04, 0);
		$display("test modem done");
		wr(8'h00, 8'hA5);
		txf(8'hA5, 1'b0);
		wr(8'h0C, 8'h1B);
		wr(8'h00, 8'hA5);
		txf(8'hA5, 1'b1);
		wr(8'h10, 8'h10);
		modem_model_inst.hold(0, 1'b0);
		wr(8'h00, 8'h3C);
		lo = 1'b0;
		repeat (200)
		begin
			@(posedge sys_clk);
			if (tx[0] !== 1'b1)
				lo = 1'b1;
		end
		chk("tx in loop", 32'(lo), 0);
		rd(8'h14, 8'h61);
		rd(8'h00, 8'h3C);
		modem_model_inst.hold(0, 1'b1);
		wr(8'h10, 0);
		wr(8'h4C, 8'h1B);
		modem_model_inst.send(1, 8'h5A, 1'b1);
		rd(8'h54, 8'h65);
		rd(8'h40, 8'h5A);
		$display("test serial done");
		bus_style <= 1'b1;
		cs_n <= 4'hD;
		repeat (4) @(posedge sys_clk);
		wr(8'h04, 8'h02);
		repeat (4) @(posedge sys_clk);
		chk("irq gated", 32'(irq), 0);
		wr(8'h10, 8'h08);
		repeat (4) @(posedge sys_clk);
		chk("irq enabled", 32'(irq), 4'h2);
		isel <= 1'b1;
		wr(8'h10, 0);
		repeat (4) @(posedge sys_clk);
		chk("irq continuous", 32'(irq), 4'h2);
		cs_n <= 4'hF;
		repeat (4) @(posedge sys_clk);
		apb(8'h04, 1'b0, 0);
		chk("no channel", 32'(rerr), 1);
		$display("test bus style done");
		results();
	end
endmodule
`default_nettype wire
